// File: sswd_pkg.sv
// Constants shared by the slave status and communication watchdog block.
// Assumes a 10 MHz system clock; all counts except STB_CYC derive from that rate.
package sswd_pkg;

    localparam int MCLK_MHZ        = 10;
    // Silence limit of the communication monitor, in microseconds
    localparam int MON_TIME_US     = 94200;
    localparam int MON_TIME_CYC    = MON_TIME_US * MCLK_MHZ;
    // Initialisation time after a logic reset, in microseconds
    localparam int INIT_TIME_US    = 2000;
    localparam int INIT_TIME_CYC   = INIT_TIME_US * MCLK_MHZ;
    // Strobe width and fault-indication blink half period
    localparam int STB_CYC         = 8;
    localparam int BLINK_TIME_US   = 250000;
    localparam int BLINK_CYC       = BLINK_TIME_US * MCLK_MHZ;

    // Status nibble field positions
    localparam int ST_MEM_BIT      = 0;
    localparam int ST_FAULT_BIT    = 1;
    localparam int ST_SPARE_BIT    = 2;
    localparam int ST_CORRUPT_BIT  = 3;

    // Reset value of replies, idle level of data/parameter outputs
    localparam logic [3:0] REPLY_RST = 4'h0;
    localparam logic [3:0] OUT_IDLE  = 4'hf;

    typedef enum logic [1:0] {
        SSWD_RUN,
        SSWD_STB,
        SSWD_RST,
        SSWD_INIT
    } sswd_state_t;

endpackage

// File: sswd_if.sv
// Carrier between the watchdog core and its timer and status modules.
// Assumes all users sit on the same mclk domain.
`timescale 1ns/10ps
interface sswd_if;
    logic       restart;
    logic       expired;
    logic       mem_busy;
    logic       addr_vol;
    logic       fault_pin_n;
    logic       parity_err;
    logic       corrupt;
    logic [3:0] nibble;

    modport tmr (input restart, output expired);
    modport sts (input mem_busy, addr_vol, fault_pin_n, parity_err,
                 corrupt, output nibble);
    modport ctl (output restart, mem_busy, addr_vol, fault_pin_n,
                 parity_err, corrupt, input expired, nibble);
endinterface

// File: sswd_timer.sv
// Silence timer: counts clock cycles since the last processed exchange or write, or the last logic reset.
// Assumes restart is a same-clock pulse from the core.
`timescale 1ns/10ps
module sswd_timer
    import sswd_pkg::*;
#(
    parameter int TERM = MON_TIME_CYC
) (
    input  logic mclk,
    input  logic srst,
    sswd_if.tmr  bus
);

    localparam int CW = $clog2(TERM + 1);
    localparam logic [CW-1:0] TERM_C = CW'(TERM);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } sswd_tmr_t;

    sswd_tmr_t st_reg;
    sswd_tmr_t st_next;

    // Saturate at the terminal count so expiry stays until restart
    always_comb begin
        st_next = st_reg;
        if (bus.restart) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt != TERM_C) begin
            st_next.cnt = CW'(st_reg.cnt + 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.expired = (st_reg.cnt == TERM_C);

    a_restart_clears: assert property (@(posedge mclk) disable iff (srst)
        bus.restart |=> !bus.expired)
        else $error("timer still expired after restart");

    a_expiry_sticks: assert property (@(posedge mclk) disable iff (srst)
        bus.expired && !bus.restart |=> bus.expired)
        else $error("timer expiry dropped without restart");

endmodule

// File: sswd_status.sv
// Status nibble assembly and periphery fault pin synchroniser.
// Assumes memory flags come from same-clock logic; the fault pin does not.
`timescale 1ns/10ps
module sswd_status
    import sswd_pkg::*;
(
    input  logic mclk,
    input  logic srst,
    sswd_if.sts  bus
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic flt_n;
    } sswd_sts_t;

    sswd_sts_t st_reg;
    sswd_sts_t st_next;
    logic      stat_bit_zero;
    logic      stat_bit_one;
    logic      stat_bit_two;
    logic      stat_bit_three;

    // Three stage sync; level accepted only once stages two and three agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = bus.fault_pin_n;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.flt_n = st_reg.s3;
        end
    end

    // All ones: pin idle high means no fault
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Nibble bits
    assign stat_bit_zero  = bus.addr_vol | bus.mem_busy;
    assign stat_bit_one   = ~st_reg.flt_n | bus.parity_err;
    assign stat_bit_two   = 1'b0;
    assign stat_bit_three = bus.corrupt;

    always_comb begin
        bus.nibble                 = '0;
        bus.nibble[ST_MEM_BIT]     = stat_bit_zero;
        bus.nibble[ST_FAULT_BIT]   = stat_bit_one;
        bus.nibble[ST_SPARE_BIT]   = stat_bit_two;
        bus.nibble[ST_CORRUPT_BIT] = stat_bit_three;
    end

    a_spare_zero: assert property (@(posedge mclk) disable iff (srst)
        !bus.nibble[ST_SPARE_BIT])
        else $error("spare status bit not zero");

    a_write_busy: assert property (@(posedge mclk) disable iff (srst)
        bus.mem_busy |-> bus.nibble[ST_MEM_BIT])
        else $error("memory bit clear during write");

    a_fault_seen: assert property (@(posedge mclk) disable iff (srst)
        !bus.fault_pin_n [*5] |-> bus.nibble[ST_FAULT_BIT])
        else $error("fault pin low but fault bit clear");

    a_corrupt_bit: assert property (@(posedge mclk) disable iff (srst)
        bus.nibble[ST_CORRUPT_BIT] == bus.corrupt)
        else $error("corrupt bit does not track memory");

endmodule

// File: sswd_top.sv
// Slave status nibble, communication monitor and communication watchdog.
// Assumes requests are one-cycle pulses from the telegram decoder on mclk,
// issued only once a request has been fully processed.
//
// Operation
// - Status-read request is answered with the four-bit status nibble.
// - Status bit two always reads zero.
// - Bit zero set when address volatile or memory write in progress.
// - Address delete with nonzero address sets status bit zero.
// - Bit zero held high through every memory write.
// - Bit one set on periphery fault pin low or memory parity error.
// - Bit three set when memory content is corrupted.
// - Red LED on after the silence limit without exchange or write.
// - Each processed exchange or write restarts timer, red LED off.
// - Monitor starts on first parameter write with nonzero address.
// - Logic reset or address delete switches the monitor off.
// - Watchdog enable from lock, inhibit, gate flag, safety, bit zero.
// - Only parameter output bit zero gates enable, never the input pin.
// - Safety mode enables watchdog regardless of parameter bit zero.
// - Timeout needs enable, silence, nonzero address, no memory write.
// - Timeout fires both strobes together with last outputs held.
// - After strobes: logic reset, set blocked flag, outputs idle.
// - Blocked flag clears only on a later parameter write.
// - While blocked both LEDs show an alternating pattern.
// - Reset request, broadcast reset or illegal state cause reset.
`timescale 1ns/10ps
module sswd_top
    import sswd_pkg::*;
#(
    parameter int MON_LEN   = MON_TIME_CYC,
    parameter int INIT_LEN  = INIT_TIME_CYC,
    parameter int BLINK_LEN = BLINK_CYC,
    parameter int STB_LEN   = STB_CYC
) (
    input  logic       mclk,
    input  logic       srst,
    input  logic       status_read_request,
    input  logic       data_exchange_request,
    input  logic       parameter_write_request,
    input  logic       address_delete_request,
    input  logic       reset_slave_request,
    input  logic       broadcast_reset_request,
    input  logic       illegal_state_detect,
    input  logic [3:0] req_data,
    input  logic [4:0] slave_address,
    input  logic       address_volatile,
    input  logic       nvm_write_active,
    input  logic       nvm_parity_error,
    input  logic       nvm_corrupt,
    input  logic       periphery_fault_n,
    input  logic       config_lock_flag,
    input  logic       wd_inhibit_flag,
    input  logic       param_bit_wd_gate_flag,
    input  logic       safety_mode_flag,
    output logic [3:0] status_reply,
    output logic       status_valid,
    output logic [3:0] data_out,
    output logic [3:0] param_out,
    output logic       data_strobe_n,
    output logic       param_strobe_n,
    output logic       green_status_led,
    output logic       red_status_led,
    output logic       exchange_blocked,
    output logic       logic_reset
);

    localparam int CW = $clog2(INIT_LEN + 1);
    localparam int SW = $clog2(STB_LEN + 1);
    localparam int BW = $clog2(BLINK_LEN + 1);
    localparam logic [CW-1:0] INIT_C  = CW'(INIT_LEN);
    localparam logic [SW-1:0] STB_C   = SW'(STB_LEN);
    localparam logic [BW-1:0] BLINK_C = BW'(BLINK_LEN - 1);

    typedef struct packed {
        sswd_state_t   state;
        logic [CW-1:0] cnt;
        logic [SW-1:0] dstb;
        logic [SW-1:0] pstb;
        logic [BW-1:0] blink_cnt;
        logic          blink;
        logic          mon_on;
        logic          del_flag;
        logic          blocked;
        logic          rst_pulse;
        logic          sv;
        logic [3:0]    reply;
        logic [3:0]    dout;
        logic [3:0]    pout;
    } sswd_top_t;

    localparam sswd_top_t ST_RST = '{
        state:     SSWD_RUN,
        cnt:       '0,
        dstb:      '0,
        pstb:      '0,
        blink_cnt: '0,
        blink:     1'b0,
        mon_on:    1'b0,
        del_flag:  1'b0,
        blocked:   1'b0,
        rst_pulse: 1'b0,
        sv:        1'b0,
        reply:     REPLY_RST,
        dout:      OUT_IDLE,
        pout:      OUT_IDLE
    };

    sswd_top_t st_reg;
    sswd_top_t st_next;
    sswd_if    core ();
    logic      addr_nz;
    logic      ext_rst;
    logic      param_port_bit_zero;
    logic      wd_en;
    logic      dx_ok;
    logic      wp_ok;
    logic      wd_fire;

    sswd_timer #(
        .TERM (MON_LEN)
    ) u_timer (
        .mclk (mclk),
        .srst (srst),
        .bus  (core.tmr)
    );

    sswd_status u_status (
        .mclk (mclk),
        .srst (srst),
        .bus  (core.sts)
    );

    // Status sources handed to the nibble builder
    assign core.mem_busy    = nvm_write_active;
    assign core.addr_vol    = address_volatile | st_reg.del_flag;
    assign core.fault_pin_n = periphery_fault_n;
    assign core.parity_err  = nvm_parity_error;
    assign core.corrupt     = nvm_corrupt;

    // Request qualification; an unblocked exchange, a write or a reset request in the same cycle beats a timeout
    assign addr_nz = |slave_address;
    assign ext_rst = reset_slave_request | broadcast_reset_request
                   | illegal_state_detect;
    assign dx_ok   = (st_reg.state == SSWD_RUN) && data_exchange_request
                   && !st_reg.blocked && !ext_rst;
    assign wp_ok   = (st_reg.state == SSWD_RUN) && parameter_write_request
                   && !ext_rst;
    assign core.restart = dx_ok | wp_ok | st_reg.rst_pulse;

    // Enable uses the output register bit only, never the port pin
    assign param_port_bit_zero = st_reg.pout[0];
    assign wd_en = config_lock_flag && !wd_inhibit_flag
                 && (!param_bit_wd_gate_flag || safety_mode_flag
                     || param_port_bit_zero);

    assign wd_fire = (st_reg.state == SSWD_RUN) && wd_en && core.expired
                   && addr_nz && !nvm_write_active
                   && !dx_ok && !wp_ok && !ext_rst;

    // Next-state logic for the whole block
    always_comb begin
        st_next           = st_reg;
        st_next.rst_pulse = 1'b0;
        st_next.sv        = 1'b0;
        // Strobe countdown; loads below override it
        if (st_reg.dstb != '0) begin
            st_next.dstb = SW'(st_reg.dstb - 1'b1);
        end
        if (st_reg.pstb != '0) begin
            st_next.pstb = SW'(st_reg.pstb - 1'b1);
        end
        // Free running blink phase for the blocked indication
        if (st_reg.blink_cnt == BLINK_C) begin
            st_next.blink_cnt = '0;
            st_next.blink     = ~st_reg.blink;
        end else begin
            st_next.blink_cnt = BW'(st_reg.blink_cnt + 1'b1);
        end
        // Reply snapshot of the nibble
        if (status_read_request) begin
            st_next.reply = core.nibble;
            st_next.sv    = 1'b1;
        end
        unique case (st_reg.state)
            SSWD_RUN: begin
                if (wd_fire) begin
                    st_next.state = SSWD_STB;
                    st_next.dstb  = STB_C;
                    st_next.pstb  = STB_C;
                end else begin
                    if (dx_ok) begin
                        st_next.dout = req_data;
                        st_next.dstb = STB_C;
                    end
                    if (wp_ok) begin
                        st_next.pout    = req_data;
                        st_next.pstb    = STB_C;
                        st_next.blocked = 1'b0;
                        if (addr_nz) begin
                            st_next.mon_on = 1'b1;
                        end
                    end
                    if (address_delete_request) begin
                        st_next.mon_on = 1'b0;
                        if (addr_nz) begin
                            st_next.del_flag = 1'b1;
                        end
                    end
                end
            end
            SSWD_STB: begin
                // Outputs stay frozen while both strobes run out
                if (st_reg.dstb == '0 && st_reg.pstb == '0) begin
                    st_next.blocked = 1'b1;
                    st_next.state   = SSWD_RST;
                end
            end
            SSWD_RST: begin
                st_next.rst_pulse = 1'b1;
                st_next.mon_on    = 1'b0;
                st_next.del_flag  = 1'b0;
                st_next.dout      = OUT_IDLE;
                st_next.pout      = OUT_IDLE;
                st_next.dstb      = '0;
                st_next.pstb      = '0;
                st_next.cnt       = INIT_C;
                st_next.state     = SSWD_INIT;
            end
            SSWD_INIT: begin
                // Exchange, write and delete requests are ignored until initialisation ends
                if (st_reg.cnt == '0) begin
                    st_next.state = SSWD_RUN;
                end else begin
                    st_next.cnt = CW'(st_reg.cnt - 1'b1);
                end
            end
        endcase
        // Any reset source restarts the sequence from the reset step
        if (ext_rst && st_reg.state != SSWD_RST) begin
            st_next.state = SSWD_RST;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Port drive
    assign status_reply     = st_reg.reply;
    assign status_valid     = st_reg.sv;
    assign data_out         = st_reg.dout;
    assign param_out        = st_reg.pout;
    assign data_strobe_n    = (st_reg.dstb == '0);
    assign param_strobe_n   = (st_reg.pstb == '0);
    assign exchange_blocked = st_reg.blocked;
    assign logic_reset      = st_reg.rst_pulse;

    // Blocked shows alternating LEDs; otherwise red marks silence
    assign green_status_led = st_reg.blocked ? st_reg.blink : 1'b1;
    assign red_status_led   = st_reg.blocked ? ~st_reg.blink
                            : (st_reg.mon_on & core.expired);

    a_status_reply: assert property (@(posedge mclk) disable iff (srst)
        status_read_request |=> status_valid
            && status_reply == $past(core.nibble))
        else $error("status reply missing or wrong");

    a_delete_mark: assert property (@(posedge mclk) disable iff (srst)
        (st_reg.state == SSWD_RUN) && !wd_fire && !ext_rst
            && address_delete_request && addr_nz
            |=> core.nibble[ST_MEM_BIT])
        else $error("address delete did not set bit zero");

    a_red_on: assert property (@(posedge mclk) disable iff (srst)
        st_reg.mon_on && core.expired && !st_reg.blocked
            |-> red_status_led)
        else $error("red LED off after silence");

    a_red_off: assert property (@(posedge mclk) disable iff (srst)
        dx_ok || wp_ok |=> !red_status_led)
        else $error("red LED stayed on after request");

    a_gate_off: assert property (@(posedge mclk) disable iff (srst)
        !config_lock_flag || wd_inhibit_flag |-> !wd_fire)
        else $error("watchdog fired while disabled");

    a_fire_strobe: assert property (@(posedge mclk) disable iff (srst)
        wd_fire |=> !data_strobe_n && !param_strobe_n
            && data_out == $past(data_out)
            && param_out == $past(param_out))
        else $error("timeout strobes not issued together");

    a_strobe_reset: assert property (@(posedge mclk) disable iff (srst)
        wd_fire |-> ##[1:40] logic_reset)
        else $error("no logic reset after timeout strobes");

    a_block_clear: assert property (@(posedge mclk) disable iff (srst)
        $fell(st_reg.blocked) && !$past(srst)
            |-> $past(parameter_write_request))
        else $error("blocked flag cleared without write");

    a_block_leds: assert property (@(posedge mclk) disable iff (srst)
        st_reg.blocked |-> green_status_led != red_status_led)
        else $error("blocked indication pattern wrong");

endmodule

// File: sswd_master_model.sv
// Bus master stand-in: issues processed-request pulses to the block.
// Assumes the bench calls its task from one process only.
`timescale 1ns/10ps
module sswd_master_model (
    input  logic       mclk,
    output logic       status_read_request,
    output logic       data_exchange_request,
    output logic       parameter_write_request,
    output logic       address_delete_request,
    output logic       reset_slave_request,
    output logic       broadcast_reset_request,
    output logic       illegal_state_detect,
    output logic [3:0] req_data
);
    logic [6:0] req_vec;

    // Quiet bus at time zero
    initial begin
        req_vec  = 7'h00;
        req_data = 4'h0;
    end

    // One request line per kind, selected by bit position
    assign {illegal_state_detect, broadcast_reset_request,
            reset_slave_request, address_delete_request,
            parameter_write_request, data_exchange_request,
            status_read_request} = req_vec;

    // One-cycle request; payload is inverted once released, so a late
    // sample by the block shows up as wrong data instead of passing
    task automatic send(input int kind, input logic [3:0] val);
        @(posedge mclk);
        #1;
        req_vec  = 7'h01 << kind;
        req_data = val;
        @(posedge mclk);
        #1;
        req_vec  = 7'h00;
        req_data = ~val;
    endtask
endmodule

// File: sswd_tb.sv
// Self-checking bench for the status nibble and communication watchdog.
// Assumes short values for the long counts and a 10 MHz mclk.
`timescale 1ns/10ps
module sswd_tb
    import sswd_pkg::*;
;
    localparam int MON = 50;
    localparam int STB = 8;
    logic       mclk, srst, status_read_request, data_exchange_request;
    logic       parameter_write_request, address_delete_request;
    logic       reset_slave_request, broadcast_reset_request;
    logic       illegal_state_detect, address_volatile, nvm_write_active;
    logic       nvm_parity_error, nvm_corrupt, periphery_fault_n;
    logic       config_lock_flag, wd_inhibit_flag, param_bit_wd_gate_flag;
    logic       safety_mode_flag, status_valid, data_strobe_n;
    logic       param_strobe_n, green_status_led, red_status_led;
    logic       exchange_blocked, logic_reset;
    logic [3:0] req_data, status_reply, data_out, param_out;
    logic [4:0] slave_address;
    logic [3:0] q_exp[$];
    int         bad_count, n_tests, n;

    sswd_top #(.MON_LEN(MON), .INIT_LEN(4), .BLINK_LEN(8), .STB_LEN(STB))
    DUT (
        .mclk, .srst, .status_read_request, .data_exchange_request,
        .parameter_write_request, .address_delete_request,
        .reset_slave_request, .broadcast_reset_request,
        .illegal_state_detect, .req_data, .slave_address,
        .address_volatile, .nvm_write_active, .nvm_parity_error,
        .nvm_corrupt, .periphery_fault_n, .config_lock_flag,
        .wd_inhibit_flag, .param_bit_wd_gate_flag, .safety_mode_flag,
        .status_reply, .status_valid, .data_out, .param_out,
        .data_strobe_n, .param_strobe_n, .green_status_led,
        .red_status_led, .exchange_blocked, .logic_reset
    );

    sswd_master_model MST (
        .mclk, .status_read_request, .data_exchange_request,
        .parameter_write_request, .address_delete_request,
        .reset_slave_request, .broadcast_reset_request,
        .illegal_state_detect, .req_data
    );

    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %b not %b", $time, got, exp);
        end
    endtask

    // Inputs change and outputs are read 1 ns after the edge
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic do_reset();
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
    endtask

    // Bounded wait on strobe, red LED or reset pulse; n > lim if not seen
    task automatic wait_for(input int sel, input int lim, input bit must);
        for (n = 1; n <= lim; n++) begin
            tick(1);
            if ((sel == 0 && data_strobe_n === 1'b0) ||
                (sel == 1 && red_status_led === 1'b1) ||
                (sel == 2 && logic_reset === 1'b1)) return;
        end
        if (must) begin
            bad_count++;
            $display("wrong value at %0t: wait ran out", $time);
            close_out();
        end
    endtask

    // Hang guard well above the expected run length
    initial begin
        #(100 * 100000);
        bad_count++;
        $display("wrong value at %0t: run limit reached", $time);
        close_out();
    end

    initial begin
        {srst, address_volatile, nvm_write_active, nvm_parity_error,
         nvm_corrupt, config_lock_flag, wd_inhibit_flag,
         param_bit_wd_gate_flag, safety_mode_flag} = 9'h100;
        periphery_fault_n = 1'b1;
        slave_address = 5'h05;
        bad_count = 0;
        n_tests = 0;
        n = $urandom(32'hfed3);
        tick(2);
        srst = 1'b0;
        chk_nib(data_out, OUT_IDLE);
        // Status nibble against random memory and fault conditions
        for (int i = 0; i < 12; i++) begin
            {address_volatile, nvm_write_active, nvm_parity_error,
             nvm_corrupt, periphery_fault_n} = 5'($urandom());
            q_exp.push_back({nvm_corrupt, 1'b0,
                nvm_parity_error | ~periphery_fault_n,
                address_volatile | nvm_write_active});
            tick(6);  // Fault pin synchroniser needs a few cycles
            // Valid stands one cycle only: look as soon as the request ends
            MST.send(0, 4'h0);
            chk_bit(status_valid, 1'b1);
            chk_nib(status_reply, q_exp.pop_front());
        end
        $display("test status nibble done");
        {address_volatile, nvm_write_active, nvm_parity_error} = 3'h0;
        {nvm_corrupt, periphery_fault_n} = 2'h1;
        // Silence timer lights red; exchange and delete switch it off
        MST.send(2, 4'h3);
        wait_for(1, MON + 20, 1'b1);
        chk_bit(n >= MON - 1 && n <= MON + 3, 1'b1);
        MST.send(1, 4'h9);
        tick(1);
        chk_bit(red_status_led, 1'b0);
        chk_nib(data_out, 4'h9);
        // Strobe low from the cycle after taking for STB cycles
        tick(STB - 2);
        chk_bit(data_strobe_n, 1'b0);
        tick(1);
        chk_bit(data_strobe_n, 1'b1);
        wait_for(1, MON + 20, 1'b1);
        MST.send(3, 4'h0);
        tick(2);
        chk_bit(red_status_led, 1'b0);
        wait_for(1, MON + 10, 1'b0);
        chk_bit(n > MON + 10, 1'b1);
        MST.send(0, 4'h0);
        tick(1);
        chk_nib(status_reply, 4'h1);
        do_reset();
        slave_address = 5'h00;
        MST.send(2, 4'h1);
        wait_for(1, MON + 10, 1'b0);
        chk_bit(n > MON + 10, 1'b1);
        slave_address = 5'h05;
        $display("test monitor done");
        // Watchdog enable table, plus one run with a memory write pending
        for (int c = 0; c < 33; c++) begin
            logic [3:0] p;
            logic       en;
            do_reset();
            {config_lock_flag, wd_inhibit_flag, param_bit_wd_gate_flag,
             safety_mode_flag} = (c == 32) ? 4'h8 : c[4:1];
            nvm_write_active = (c == 32);
            p = {3'($urandom()), c[0]};
            en = config_lock_flag & ~wd_inhibit_flag & ~nvm_write_active
                 & (~param_bit_wd_gate_flag | safety_mode_flag | p[0]);
            MST.send(1, 4'h6);
            MST.send(2, p);
            tick(STB + 2);
            wait_for(0, MON + 20, 1'b0);
            chk_bit(n <= MON + 20, en);
            if (en) begin
                chk_bit(param_strobe_n, 1'b0);
                chk_nib(data_out, 4'h6);
                chk_nib(param_out, p);
                wait_for(2, 30, 1'b1);
                chk_nib(data_out, OUT_IDLE);
                chk_nib(param_out, OUT_IDLE);
                chk_bit(exchange_blocked, 1'b1);
                chk_bit(red_status_led, ~green_status_led);
                tick(8);
                MST.send(1, 4'h5);
                tick(1);
                chk_nib(data_out, OUT_IDLE);
                MST.send(2, 4'h2);
                tick(1);
                chk_bit(exchange_blocked, 1'b0);
                MST.send(1, 4'h5);
                tick(1);
                chk_nib(data_out, 4'h5);
            end
        end
        $display("test watchdog done");
        {nvm_write_active, config_lock_flag} = 2'h0;
        // Reset commands and the illegal-state alarm force a logic reset
        for (int k = 4; k < 7; k++) begin
            MST.send(2, 4'h4);
            MST.send(1, 4'h7);
            MST.send(k, 4'h0);
            wait_for(2, 5, 1'b1);
            chk_nib(data_out, OUT_IDLE);
            chk_bit(exchange_blocked, 1'b0);
            tick(8);
        end
        $display("test reset requests done");
        close_out();
    end
endmodule
